// >>> shared/flow_pkg.sv
// package for the program-flow and stack block: widths, map, commands, carriers
// assumes one core clock and a synchronous active-high reset
`default_nettype none
package flow_pkg;
  localparam int IP_W = 14;
  localparam int PAGE_W = 8;
  localparam int RAM_AW = 8;
  localparam int RAM_DEPTH = 256;
  localparam logic [13:0] RESET_ADDR = 14'h0000;
  localparam logic [13:0] VEC_BUS_RESET = 14'h0002;
  localparam logic [13:0] VEC_STEP = 14'h0002;
  localparam logic [13:0] VEC_LAST = 14'h0018;
  localparam logic [13:0] PROG_START = 14'h001A;
  localparam logic [13:0] PROG_END = 14'h1FDF;
  localparam logic [7:0] RSP_RESET = 8'h00;
  localparam logic [7:0] OSP_RESET = 8'h00;
  localparam logic [3:0] IRQ_COUNT = 4'hC;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_STEP1, CMD_STEP2, CMD_JUMP, CMD_PAGE_ADVANCE, CMD_CALL,
    CMD_SUB_RETURN, CMD_INT_RETURN, CMD_RSP_LOAD, CMD_PUSH, CMD_POP,
    CMD_OSP_SWAP, CMD_OPERAND
  } cmd_t;

  typedef enum logic [1:0] {MODE_IMMEDIATE, MODE_DIRECT, MODE_INDEXED} addr_mode_t;

  typedef struct packed {
    cmd_t cmd;
    addr_mode_t mode;
    logic [13:0] target;
    logic [7:0] operand_byte;
    logic [7:0] acc;
    logic [7:0] index_x;
    logic carry;
    logic zero;
  } flow_req_t;

  typedef struct packed {
    logic [13:0] ip;
    logic carry;
    logic zero;
    logic int_enable;
    logic busy;
    logic done;
    logic [7:0] data;
    logic [7:0] acc_swap;
    logic [7:0] operand_addr;
  } flow_rsp_t;
endpackage : flow_pkg
`default_nettype wire

// >>> hdl/flow_ram.sv
// 256-byte data ram shared by return stack, variables, operand stack, usb buffers
// assumes single port, synchronous write, combinational read
`default_nettype none
module flow_ram (
  input wire logic core_clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [flow_pkg::RAM_DEPTH];

  always_ff @(posedge core_clk) begin
    if (ce && we) begin
      mem[addr] <= wdata;
    end
  end

  assign rdata = mem[addr];
endmodule : flow_ram
`default_nettype wire

// >>> hdl/flow_operand_addr.sv
// operand address generation for immediate, direct and indexed modes
// assumes the second instruction byte and index register are stable inputs
`default_nettype none
module flow_operand_addr (
  input wire flow_pkg::addr_mode_t mode,
  input wire logic [7:0] operand_byte,
  input wire logic [7:0] index_x,
  output logic use_ram,
  output logic [7:0] addr
);
  always_comb begin
    use_ram = 1'b1;
    addr = operand_byte;
    case (mode)
      flow_pkg::MODE_IMMEDIATE: begin
        use_ram = 1'b0; // R19
      end
      flow_pkg::MODE_DIRECT: begin
        addr = operand_byte; // R20
      end
      flow_pkg::MODE_INDEXED: begin
        addr = 8'(operand_byte + index_x); // R21
      end
      default: begin
        use_ram = 1'b0;
      end
    endcase
  end
endmodule : flow_operand_addr
`default_nettype wire

// >>> hdl/flow_core.sv
// program-flow, return stack and operand stack logic of the 8-bit core
// assumes the decoder issues one command while busy is low and holds it one cycle
// Operation
// R1: instruction pointer is 14 bits and clears to zero on reset.
// R2: sequential fetch advances only the low eight pointer bits.
// R3: page-advance command increments the upper six pointer bits.
// R4: low byte wraps within its page without carry upward.
// R5: interrupt or call saves next address and flags as two bytes.
// R6: interrupt return restores pointer and flags; subroutine return only pointer.
// R7: return stack pointer resets to zero and grows upward.
// R8: return stack pointer loads from accumulator; it is never read back.
// R9: interrupt entry disables interrupts, writes byte, increments, writes, increments.
// R10: interrupt return decrements, restores second, decrements, restores first, then enables.
// R11: pointer not firmware-accessible; saved entries visible in ram from zero.
// R12: vectors two bytes apart from 0x0002 to 0x0018; code from 0x001A.
// R13: usable program memory ends at 0x1FDF; top 32 bytes reserved.
// R14: 256 bytes of shared data ram.
// R15: push pre-decrements then writes; pop reads then post-increments.
// R16: operand stack pointer resets to zero; first push writes 0xFF.
// R17: exchange swaps accumulator with operand stack pointer.
// R18: firmware should move operand stack below usb buffers, e.g. 0xD8.
// R19: immediate mode uses second instruction byte as constant.
// R20: direct mode uses second byte as ram address.
// R21: indexed mode adds instruction constant to index register.
// R22: reset entry at zero pushes nothing onto the return stack.
`default_nettype none
module flow_core (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire flow_pkg::flow_req_t req,
  input wire logic req_valid,
  input wire logic irq_req,
  input wire logic [3:0] irq_index,
  input wire logic int_enable_set,
  input wire logic int_enable_clr,
  input wire logic ram_wr,
  input wire logic [7:0] ram_addr,
  input wire logic [7:0] ram_wdata,
  output flow_pkg::flow_rsp_t rsp,
  output logic irq_ack,
  output logic [3:0] irq_taken
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_SAVE_HI, ST_SAVE_LO, ST_REST_HI, ST_REST_LO
  } state_t;

  state_t state_q;
  logic [13:0] ip_q;
  logic [13:0] save_ip_q;
  logic carry_q;
  logic zero_q;
  logic int_en_q;
  logic rest_flags_q;
  logic [7:0] rsp_q;
  logic [7:0] osp_q;
  logic [7:0] low_byte_q;
  logic [7:0] data_q;
  logic [7:0] acc_swap_q;
  logic [7:0] opnd_addr_q;
  logic done_q;
  logic irq_ack_q;
  logic [3:0] irq_taken_q;
  logic busy_q;
  logic [13:0] req_target_q;

  logic mem_we;
  logic [7:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic opnd_use_ram;
  logic [7:0] opnd_addr;
  logic take_irq;
  logic cmd_go;

  // the first byte saved carries the flags in bits 7:6
  logic [7:0] first_byte;
  assign first_byte = {carry_q, zero_q, save_ip_q[13:8]};

  // low byte advances and wraps inside the page
  function automatic logic [13:0] seq_next(input logic [13:0] ip, input logic [1:0] len);
    seq_next = {ip[13:8], 8'(ip[7:0] + {6'h00, len})};
  endfunction : seq_next

  function automatic logic [13:0] vector_of(input logic [3:0] idx);
    vector_of = 14'(flow_pkg::VEC_BUS_RESET + 14'(idx) * flow_pkg::VEC_STEP);
  endfunction : vector_of

  // targets past usable program memory restart from zero
  function automatic logic [13:0] legal_target(input logic [13:0] t);
    legal_target = (t > flow_pkg::PROG_END) ? flow_pkg::RESET_ADDR : t;
  endfunction : legal_target

  // the reserved slot and indexes past the map are never taken
  function automatic logic irq_slot_ok(input logic [3:0] idx);
    irq_slot_ok = (idx < flow_pkg::IRQ_COUNT) && (idx != 4'h8);
  endfunction : irq_slot_ok

  assign cmd_go = ce && req_valid && (state_q == ST_IDLE);
  assign take_irq = ce && irq_req && int_en_q && (state_q == ST_IDLE) && !req_valid
    && irq_slot_ok(irq_index); // R12

  flow_operand_addr u_opnd (
    .mode(req.mode),
    .operand_byte(req.operand_byte),
    .index_x(req.index_x),
    .use_ram(opnd_use_ram),
    .addr(opnd_addr)
  );

  flow_ram u_ram ( // R14
    .core_clk(core_clk),
    .ce(ce),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // one ram port: stack sequencing wins, else push/pop/operand, else external access
  always_comb begin
    mem_we = 1'b0;
    mem_addr = ram_addr;
    mem_wdata = ram_wdata;
    case (state_q)
      ST_SAVE_HI: begin
        mem_we = 1'b1;
        mem_addr = rsp_q; // R9
        mem_wdata = first_byte; // R5
      end
      ST_SAVE_LO: begin
        mem_we = 1'b1;
        mem_addr = rsp_q; // R9
        mem_wdata = save_ip_q[7:0];
      end
      ST_REST_HI: begin
        mem_addr = 8'(rsp_q - 8'h01); // R10
      end
      ST_REST_LO: begin
        mem_addr = 8'(rsp_q - 8'h01); // R10
      end
      default: begin
        if (cmd_go && req.cmd == flow_pkg::CMD_PUSH) begin
          mem_we = 1'b1;
          mem_addr = 8'(osp_q - 8'h01); // R15 R16
          mem_wdata = req.acc;
        end else if (cmd_go && req.cmd == flow_pkg::CMD_POP) begin
          mem_addr = osp_q; // R15
        end else if (cmd_go && req.cmd == flow_pkg::CMD_OPERAND) begin
          mem_addr = opnd_addr;
        end else begin
          mem_we = ram_wr; // R11
        end
      end
    endcase
  end

  // two-byte layout: first byte holds flags and upper pointer bits, second low bits
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      save_ip_q <= 14'h0000;
      rest_flags_q <= 1'b0;
      low_byte_q <= 8'h00;
      busy_q <= 1'b0;
    end else if (ce) begin
      case (state_q)
        // busy follows the next state so the port comes straight from a flop
        ST_IDLE: begin
          if (take_irq) begin
            save_ip_q <= ip_q; // R5
            state_q <= ST_SAVE_HI;
            busy_q <= 1'b1;
          end else if (cmd_go && req.cmd == flow_pkg::CMD_CALL) begin
            save_ip_q <= seq_next(ip_q, 2'd2); // R5
            state_q <= ST_SAVE_HI;
            busy_q <= 1'b1;
          end else if (cmd_go && req.cmd == flow_pkg::CMD_INT_RETURN) begin
            rest_flags_q <= 1'b1; // R6
            state_q <= ST_REST_HI;
            busy_q <= 1'b1;
          end else if (cmd_go && req.cmd == flow_pkg::CMD_SUB_RETURN) begin
            rest_flags_q <= 1'b0; // R6
            state_q <= ST_REST_HI;
            busy_q <= 1'b1;
          end
        end
        ST_SAVE_HI: begin
          state_q <= ST_SAVE_LO;
        end
        ST_SAVE_LO: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
        // the second byte comes back first and waits here for the flags byte
        ST_REST_HI: begin
          low_byte_q <= mem_rdata; // R10
          state_q <= ST_REST_LO;
        end
        ST_REST_LO: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rsp_q <= flow_pkg::RSP_RESET; // R7
    end else if (ce) begin
      if (state_q == ST_SAVE_HI || state_q == ST_SAVE_LO) begin
        rsp_q <= 8'(rsp_q + 8'h01); // R7 R9
      end else if (state_q == ST_REST_HI || state_q == ST_REST_LO) begin
        rsp_q <= 8'(rsp_q - 8'h01); // R10
      end else if (cmd_go && req.cmd == flow_pkg::CMD_RSP_LOAD) begin
        rsp_q <= req.acc; // R8
      end
    end
  end

  // no output exposes the return stack pointer value itself
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ip_q <= flow_pkg::RESET_ADDR; // R1 R22
    end else if (ce) begin
      if (state_q == ST_SAVE_LO && irq_ack_q) begin
        ip_q <= vector_of(irq_taken_q); // R12
      end else if (state_q == ST_SAVE_LO) begin
        ip_q <= req_target_q;
      end else if (state_q == ST_REST_LO) begin
        ip_q <= {mem_rdata[5:0], low_byte_q}; // R6
      end else if (cmd_go) begin
        case (req.cmd)
          flow_pkg::CMD_STEP1: ip_q <= seq_next(ip_q, 2'd1); // R2 R4
          flow_pkg::CMD_STEP2: ip_q <= seq_next(ip_q, 2'd2); // R2 R4
          flow_pkg::CMD_OPERAND: ip_q <= seq_next(ip_q, 2'd2); // R2
          flow_pkg::CMD_PAGE_ADVANCE: ip_q <= {6'(ip_q[13:8] + 6'h01), 8'h00}; // R3
          flow_pkg::CMD_JUMP: ip_q <= legal_target(req.target); // R13
          default: ip_q <= ip_q;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      req_target_q <= flow_pkg::PROG_START;
    end else if (ce && cmd_go && req.cmd == flow_pkg::CMD_CALL) begin
      req_target_q <= legal_target(req.target); // R13
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      carry_q <= 1'b0;
      zero_q <= 1'b0;
    end else if (ce) begin
      if (state_q == ST_REST_LO && rest_flags_q) begin
        carry_q <= mem_rdata[7]; // R6
        zero_q <= mem_rdata[6]; // R6
      end else if (cmd_go && req.cmd != flow_pkg::CMD_INT_RETURN
          && req.cmd != flow_pkg::CMD_SUB_RETURN) begin // R6
        carry_q <= req.carry;
        zero_q <= req.zero;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      int_en_q <= 1'b0;
    end else if (ce) begin
      if (take_irq) begin
        int_en_q <= 1'b0; // R9
      end else if (state_q == ST_REST_LO && rest_flags_q) begin
        int_en_q <= 1'b1; // R10
      end else if (int_enable_clr) begin
        int_en_q <= 1'b0;
      end else if (int_enable_set) begin
        int_en_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      osp_q <= flow_pkg::OSP_RESET; // R16
      acc_swap_q <= 8'h00;
    end else if (ce && cmd_go) begin
      if (req.cmd == flow_pkg::CMD_PUSH) begin
        osp_q <= 8'(osp_q - 8'h01); // R15
      end else if (req.cmd == flow_pkg::CMD_POP) begin
        osp_q <= 8'(osp_q + 8'h01); // R15
      end else if (req.cmd == flow_pkg::CMD_OSP_SWAP) begin
        osp_q <= req.acc; // R17
        acc_swap_q <= osp_q; // R17
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data_q <= 8'h00;
      opnd_addr_q <= 8'h00;
    end else if (ce && cmd_go) begin
      if (req.cmd == flow_pkg::CMD_POP) begin
        data_q <= mem_rdata;
      end else if (req.cmd == flow_pkg::CMD_OPERAND) begin
        opnd_addr_q <= opnd_addr;
        data_q <= opnd_use_ram ? mem_rdata : req.operand_byte; // R19
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      done_q <= 1'b0;
      irq_ack_q <= 1'b0;
      irq_taken_q <= 4'h0;
    end else if (ce) begin
      done_q <= (cmd_go && req.cmd != flow_pkg::CMD_CALL
        && req.cmd != flow_pkg::CMD_INT_RETURN && req.cmd != flow_pkg::CMD_SUB_RETURN
        && req.cmd != flow_pkg::CMD_NONE)
        || state_q == ST_SAVE_LO || state_q == ST_REST_LO;
      if (take_irq) begin
        irq_ack_q <= 1'b1;
        irq_taken_q <= irq_index;
      end else if (state_q == ST_SAVE_LO) begin
        irq_ack_q <= 1'b0;
      end
    end
  end

  assign rsp = '{ip: ip_q, carry: carry_q, zero: zero_q, int_enable: int_en_q,
    busy: busy_q, done: done_q, data: data_q, acc_swap: acc_swap_q,
    operand_addr: opnd_addr_q};
  assign irq_ack = irq_ack_q;
  assign irq_taken = irq_taken_q;
endmodule : flow_core
`default_nettype wire

// >>> verif/flow_core_chk.sv
// checker for flow_core: pointer, stack and operand timing seen at the ports
// assumes it is bound onto flow_core, one core clock, synchronous reset
`default_nettype none
module flow_core_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic ce,
  input wire flow_pkg::flow_req_t req,
  input wire logic req_valid,
  input wire logic irq_req,
  input wire logic [3:0] irq_index,
  input wire flow_pkg::flow_rsp_t rsp,
  input wire logic irq_ack
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  wire logic take = ce && req_valid && !rsp.busy;
  // slot 8 is reserved and indexes past the map are ignored
  wire logic itake = ce && irq_req && rsp.int_enable && !rsp.busy && !req_valid
    && irq_index != 4'h8 && irq_index < flow_pkg::IRQ_COUNT;

  property p_reset_entry;
    $fell(rst) |-> rsp.ip == 14'h0000 && !rsp.int_enable && !rsp.busy && !rsp.done;
  endproperty
  a_reset_entry: assert property (p_reset_entry)
    else $error("state after reset wrong");
  property p_step1;
    take && req.cmd == flow_pkg::CMD_STEP1
      |=> rsp.done && rsp.ip == {$past(rsp.ip[13:8]), $past(rsp.ip[7:0]) + 8'h01};
  endproperty
  a_step1: assert property (p_step1)
    else $error("one byte step wrong");
  property p_step2;
    take && req.cmd == flow_pkg::CMD_STEP2
      |=> $stable(rsp.ip[13:8]) && rsp.ip[7:0] == $past(rsp.ip[7:0]) + 8'h02;
  endproperty
  a_step2: assert property (p_step2)
    else $error("two byte step wrong");
  property p_page;
    take && req.cmd == flow_pkg::CMD_PAGE_ADVANCE
      |=> rsp.ip[13:8] == $past(rsp.ip[13:8]) + 6'h01;
  endproperty
  a_page: assert property (p_page)
    else $error("page advance wrong");
  property p_call;
    take && req.cmd == flow_pkg::CMD_CALL && req.target <= flow_pkg::PROG_END
      |=> rsp.busy [*2] ##1 (!rsp.busy && rsp.done && rsp.ip == $past(req.target, 3));
  endproperty
  a_call: assert property (p_call)
    else $error("call sequence wrong");
  property p_irq_take;
    itake |=> !rsp.int_enable && irq_ack;
  endproperty
  a_irq_take: assert property (p_irq_take)
    else $error("interrupt entry did not disable");
  property p_vector;
    itake |-> ##3 rsp.done
      && rsp.ip == flow_pkg::VEC_BUS_RESET + {9'h000, $past(irq_index, 3), 1'b0};
  endproperty
  a_vector: assert property (p_vector)
    else $error("vector address wrong");
  property p_sub_ret;
    take && req.cmd == flow_pkg::CMD_SUB_RETURN |-> ##3 rsp.done
      && rsp.carry == $past(rsp.carry, 3) && rsp.zero == $past(rsp.zero, 3);
  endproperty
  a_sub_ret: assert property (p_sub_ret)
    else $error("subroutine return touched flags");
  property p_int_ret;
    take && req.cmd == flow_pkg::CMD_INT_RETURN && !rsp.int_enable
      |=> !rsp.int_enable [*2] ##1 (rsp.int_enable && rsp.done);
  endproperty
  a_int_ret: assert property (p_int_ret)
    else $error("interrupt return enable timing wrong");
  property p_direct;
    take && req.cmd == flow_pkg::CMD_OPERAND && req.mode == flow_pkg::MODE_DIRECT
      |=> rsp.operand_addr == $past(req.operand_byte);
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct address wrong");
  property p_indexed;
    take && req.cmd == flow_pkg::CMD_OPERAND && req.mode == flow_pkg::MODE_INDEXED
      |=> rsp.operand_addr == $past(req.operand_byte) + $past(req.index_x);
  endproperty
  a_indexed: assert property (p_indexed)
    else $error("indexed address wrong");
endmodule : flow_core_chk

bind flow_core flow_core_chk chk (.core_clk(core_clk), .rst(rst), .ce(ce), .req(req),
  .req_valid(req_valid), .irq_req(irq_req), .irq_index(irq_index), .rsp(rsp),
  .irq_ack(irq_ack));
`default_nettype wire

// >>> verif/flow_core_tb_top.sv
// self-checking bench for flow_core: random and corner flow, stack, operand traffic
// assumes flow_core_chk is bound from its own file
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module flow_core_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic req_valid = 1'b0;
  logic irq_req = 1'b0;
  logic [3:0] irq_index = 4'h0;
  logic int_enable_set = 1'b0;
  logic int_enable_clr = 1'b0;
  logic ram_wr = 1'b0;
  logic [7:0] ram_addr = 8'h00;
  logic [7:0] ram_wdata = 8'h00;
  flow_pkg::flow_req_t req = '0;
  flow_pkg::flow_rsp_t rsp;
  logic irq_ack;
  logic [3:0] irq_taken;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [13:0] ipm, ret;
  logic [7:0] v1, v2, a, x;
  logic [1:0] fl;
  always #25 core_clk = ~core_clk;
  flow_core uut (.core_clk(core_clk), .rst(rst), .ce(ce), .req(req), .req_valid(req_valid),
    .irq_req(irq_req), .irq_index(irq_index), .int_enable_set(int_enable_set),
    .int_enable_clr(int_enable_clr), .ram_wr(ram_wr), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .rsp(rsp), .irq_ack(irq_ack), .irq_taken(irq_taken));

  function automatic logic [13:0] seq_ip(logic [13:0] p, logic [7:0] n);
    return {p[13:8], p[7:0] + n};
  endfunction : seq_ip
  function automatic logic [13:0] vec_ip(logic [3:0] i);
    return flow_pkg::VEC_BUS_RESET + {9'h000, i, 1'b0};
  endfunction : vec_ip
  function automatic logic [13:0] rnd_ip();
    return 14'($urandom_range(flow_pkg::PROG_END, flow_pkg::PROG_START));
  endfunction : rnd_ip
  task automatic stop_test();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test
  task automatic do_reset();
    rst = 1'b1;
    repeat (8) @(negedge core_clk);
    rst = 1'b0;
  endtask : do_reset
  task automatic ram_put(logic [7:0] ad, logic [7:0] d);
    ram_addr = ad;
    ram_wdata = d;
    ram_wr = 1'b1;
    @(negedge core_clk);
    ram_wr = 1'b0;
  endtask : ram_put
  // one command per call; valid held for one edge, then wait up to 8 edges for done, then one idle edge
  task automatic run(flow_pkg::cmd_t c, logic [13:0] t = 14'h0000, logic [7:0] b = 8'h00,
      logic [7:0] acc_v = 8'h00, flow_pkg::addr_mode_t m = flow_pkg::MODE_IMMEDIATE,
      logic [7:0] xi = 8'h00, logic [1:0] fl = 2'b00);
    flow_pkg::flow_req_t r;
    r = '0;
    r.cmd = c;
    r.target = t;
    r.operand_byte = b;
    r.acc = acc_v;
    r.mode = m;
    r.index_x = xi;
    r.carry = fl[1];
    r.zero = fl[0];
    req = r;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    for (int n = 0; n < 8 && rsp.done !== 1'b1; n++) @(negedge core_clk);
    `CHK("done", 1'b1, rsp.done)
    @(negedge core_clk);
  endtask : run

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      stop_test();
    end
  end

  initial begin
    v1 = 8'($urandom(32'h5d94));
    do_reset();
    `CHK("ip", 14'h0000, rsp.ip)
    run(flow_pkg::CMD_OSP_SWAP);
    `CHK("osp", 8'h00, rsp.acc_swap)
    $display("test reset done");
    run(flow_pkg::CMD_JUMP, 14'h1FE0);
    `CHK("jump end", 14'h0000, rsp.ip)
    for (int k = 0; k < 48; k++) begin
      if (k % 8 == 0) begin
        ipm = rnd_ip();
        // low byte at the top of a page to force the wrap
        if (k == 16) ipm = {1'b0, ipm[12:8], 8'hFF};
        run(flow_pkg::CMD_JUMP, ipm);
      end else if (k % 8 == 7) begin
        run(flow_pkg::CMD_PAGE_ADVANCE);
        ipm[13:8] = ipm[13:8] + 6'h01;
        `CHK("page", ipm[13:8], rsp.ip[13:8])
        continue;
      end else begin
        v1 = 8'($urandom_range(2, 1));
        run(v1 == 8'h01 ? flow_pkg::CMD_STEP1 : flow_pkg::CMD_STEP2);
        ipm = seq_ip(ipm, v1);
      end
      `CHK("ip", ipm, rsp.ip)
    end
    // clock enable low: a held request must not move the pointer
    ipm = rnd_ip();
    run(flow_pkg::CMD_JUMP, ipm);
    ce = 1'b0;
    req.cmd = flow_pkg::CMD_STEP1;
    req_valid = 1'b1;
    @(negedge core_clk);
    req_valid = 1'b0;
    ce = 1'b1;
    `CHK("freeze", ipm, rsp.ip)
    @(negedge core_clk);
    $display("test sequence done");
    for (int j = 0; j < 2; j++) begin
      a = j ? 8'h40 : 8'h00;
      run(flow_pkg::CMD_RSP_LOAD, , , a);
      ipm = rnd_ip();
      run(flow_pkg::CMD_JUMP, ipm);
      ret = seq_ip(ipm, 8'h02);
      ipm = rnd_ip();
      fl = 2'($urandom);
      run(flow_pkg::CMD_CALL, ipm, , , , , fl);
      `CHK("call ip", ipm, rsp.ip)
      run(flow_pkg::CMD_OSP_SWAP, , , a);
      run(flow_pkg::CMD_POP);
      `CHK("stack hi", ret[13:8], rsp.data[5:0])
      `CHK("stack flags", fl, rsp.data[7:6])
      run(flow_pkg::CMD_POP, , , , , , fl);
      `CHK("stack lo", ret[7:0], rsp.data)
      run(flow_pkg::CMD_SUB_RETURN);
      `CHK("ret ip", ret, rsp.ip)
      `CHK("ret carry", fl[1], rsp.carry)
      `CHK("ret zero", fl[0], rsp.zero)
    end
    $display("test call done");
    for (int i = 0; i < 12; i++) begin
      if (i == 8) continue;
      ipm = rnd_ip();
      fl = 2'($urandom);
      run(flow_pkg::CMD_JUMP, ipm, , , , , fl);
      int_enable_set = 1'b1;
      @(negedge core_clk);
      int_enable_set = 1'b0;
      irq_index = 4'(i);
      irq_req = 1'b1;
      for (int n = 0; n < 10 && rsp.done !== 1'b1; n++) @(negedge core_clk);
      irq_req = 1'b0;
      `CHK("vector", vec_ip(4'(i)), rsp.ip)
      `CHK("taken", 4'(i), irq_taken)
      `CHK("int_en", 1'b0, rsp.int_enable)
      run(flow_pkg::CMD_INT_RETURN);
      `CHK("interrupt_return_op ip", ipm, rsp.ip)
      `CHK("int_en", 1'b1, rsp.int_enable)
      `CHK("interrupt_return_op carry", fl[1], rsp.carry)
      `CHK("interrupt_return_op zero", fl[0], rsp.zero)
    end
    $display("test interrupt done");
    v1 = 8'($urandom);
    v2 = 8'($urandom);
    run(flow_pkg::CMD_OSP_SWAP, , , 8'h00);
    run(flow_pkg::CMD_PUSH, , , v1);
    run(flow_pkg::CMD_PUSH, , , v2);
    run(flow_pkg::CMD_POP);
    `CHK("pop", v2, rsp.data)
    run(flow_pkg::CMD_OSP_SWAP, , , 8'hFF);
    `CHK("osp", 8'hFF, rsp.acc_swap)
    run(flow_pkg::CMD_POP);
    `CHK("pop top", v1, rsp.data)
    run(flow_pkg::CMD_OSP_SWAP, , , 8'h20);
    `CHK("osp wrap", 8'h00, rsp.acc_swap)
    $display("test operand stack done");
    for (int k = 0; k < 15; k++) begin
      a = 8'($urandom);
      v1 = 8'($urandom);
      x = 8'($urandom);
      ram_put(a, v1);
      if (k % 3 == 0) begin
        run(flow_pkg::CMD_OPERAND, , x);
        `CHK("imm", x, rsp.data)
      end else begin
        if (k % 3 == 2) run(flow_pkg::CMD_OPERAND, , a - x, , flow_pkg::MODE_INDEXED, x);
        else run(flow_pkg::CMD_OPERAND, , a, , flow_pkg::MODE_DIRECT);
        `CHK("addr", a, rsp.operand_addr)
        `CHK("ram", v1, rsp.data)
      end
    end
    $display("test addressing done");
    // reset entry must leave the stack area untouched
    ram_put(8'h00, 8'hC3);
    do_reset();
    `CHK("ip", 14'h0000, rsp.ip)
    run(flow_pkg::CMD_POP);
    `CHK("no save", 8'hC3, rsp.data)
    $display("test second reset done");
    stop_test();
  end
endmodule : flow_core_tb_top
`default_nettype wire
